//--- core/pco_blink.sv
// free running blink phase and one second tick
`timescale 1ns/1ps
module pco_blink import pco_pkg::*; #(
    parameter int PERIOD_CYC = BLINK_PERIOD_CYC,
    parameter int INV_CYC    = BLINK_INV_CYC,
    parameter int SEC_C      = SEC_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // timing out
    pco_ctl_if.tmr   t
);
    localparam int CW = $clog2(PERIOD_CYC);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          inv;
        logic          tick;
    } pco_blink_st_t;
    pco_blink_st_t s, n;

    always_comb begin
        n = s;
        n.cnt = (s.cnt == CW'(PERIOD_CYC - 1)) ? '0 : s.cnt + 1'b1;
        n.inv = (n.cnt < CW'(INV_CYC));
        n.tick = (s.cnt == CW'(SEC_C - 1)) || (s.cnt == CW'(PERIOD_CYC - 1));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign t.sec_tick  = s.tick;
    assign t.blink_inv = s.inv;
endmodule

//--- core/pco_chan.sv
// one process channel: manual override, pause and time-out
`timescale 1ns/1ps
module pco_chan import pco_pkg::*; #(
    parameter int IDX = 0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    pco_ctl_if.chan  c,
    // state
    output logic     relay,
    output logic     manual
);
    typedef struct packed {
        logic            manual;
        logic            relay;
        logic            timing;
        logic            done;
        logic [TO_W-1:0] tmr;
    } pco_chan_st_t;
    pco_chan_st_t s, n;
    logic cnd;
    logic rel;

    assign cnd = c.cond[IDX];
    // restart releases even while paused; single release only when running
    assign rel = s.manual && (c.restart || (c.release_v[IDX] && !c.paused));

    always_comb begin
        n = s;
        if (c.pause_rst) begin
            n = '0;
        end else if (rel) begin
            n.manual = 1'b0;
            n.done   = 1'b0;
            n.relay  = cnd;
            n.timing = cnd && (c.to_sec != '0);
            n.tmr    = cnd ? c.to_sec : '0;
        end else if (c.toggle[IDX]) begin
            if (!s.manual) begin
                n.manual = 1'b1;
            end else begin
                n.relay = !s.relay;
            end
        end else if (!s.manual && !c.paused) begin
            if (!cnd) begin
                n.relay  = 1'b0;
                n.timing = 1'b0;
                n.done   = 1'b0;
                n.tmr    = '0;
            end else if (!s.timing && !s.done && !s.relay) begin
                n.relay  = 1'b1;
                n.timing = (c.to_sec != '0);
                n.tmr    = c.to_sec;
            end else if (s.timing && c.sec_tick) begin
                if (s.tmr <= TO_W'(1)) begin
                    n.timing = 1'b0;
                    n.done   = 1'b1;
                    n.relay  = 1'b0;
                end else begin
                    n.tmr = s.tmr - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign relay  = s.relay;
    assign manual = s.manual;

    chk_manual_enter: assert property (@(posedge pclk) disable iff (!presetn)
        c.toggle[IDX] && !s.manual && !c.pause_rst && !rel
        |=> s.manual && s.relay == $past(s.relay))
        else $error("first toggle did not enter manual with relay held");
    chk_manual_flip: assert property (@(posedge pclk) disable iff (!presetn)
        c.toggle[IDX] && s.manual && !c.pause_rst && !rel
        |=> s.relay != $past(s.relay))
        else $error("toggle in manual did not invert relay");
    chk_release_ign: assert property (@(posedge pclk) disable iff (!presetn)
        c.release_v[IDX] && c.paused && !c.restart && !c.pause_rst
        |=> s.manual == $past(s.manual))
        else $error("release honoured during pause");
    chk_release_auto: assert property (@(posedge pclk) disable iff (!presetn)
        rel && !c.pause_rst |=> !s.manual && s.relay == $past(cnd)
        && s.timing == ($past(cnd) && $past(c.to_sec) != '0))
        else $error("release did not reach power-up or start time-out");
    chk_pause_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        c.paused && !s.manual && !c.pause_rst && !rel && !c.toggle[IDX]
        |=> $stable(s.relay) && $stable(s.tmr))
        else $error("paused channel changed");
    chk_pause_rst: assert property (@(posedge pclk) disable iff (!presetn)
        c.pause_rst |=> !s.relay && !s.manual && !s.timing)
        else $error("pause-reset left channel active");
endmodule

//--- core/pco_ctl_if.sv
// shared control signals between the top, blink timer and channels
`timescale 1ns/1ps
interface pco_ctl_if #(parameter int N = 12, parameter int TW = 10);
    logic          sec_tick;
    logic          blink_inv;
    logic          paused;
    logic          pause_rst;
    logic          restart;
    logic [N-1:0]  toggle;
    logic [N-1:0]  release_v;
    logic [N-1:0]  cond;
    logic [TW-1:0] to_sec;
    modport tmr  (output sec_tick, output blink_inv);
    modport chan (input sec_tick, input paused, input pause_rst, input restart,
                  input toggle, input release_v, input cond, input to_sec);
endinterface

//--- core/pco_pkg.sv
// constants for the process channel override control block
package pco_pkg;
    localparam int CLK_HZ          = 50_000_000;
    localparam int BLINK_PERIOD_MS = 2000;
    localparam int BLINK_INV_MS    = 500;
    localparam int SEC_MS          = 1000;
    localparam int BLINK_PERIOD_CYC = CLK_HZ / 1000 * BLINK_PERIOD_MS;
    localparam int BLINK_INV_CYC    = CLK_HZ / 1000 * BLINK_INV_MS;
    localparam int SEC_CYC          = CLK_HZ / 1000 * SEC_MS;
    localparam int NCH  = 12;
    localparam int TO_W = 10;
    localparam logic [TO_W-1:0] TO_RST = 10'h00A;
    localparam logic [6:0] CODE_PAUSE     = 7'h20;
    localparam logic [6:0] CODE_PAUSE_RST = 7'h21;
    localparam logic [6:0] CODE_RESTART   = 7'h22;
    localparam logic [6:0] CODE_VIEW      = 7'h23;
    localparam logic [6:0] CODE_MAN_BASE  = 7'h29;
    localparam logic [6:0] CODE_AUTO_BASE = 7'h47;
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_PRESS  = 8'h08;
    localparam logic [7:0] OFS_TO     = 8'h0C;
    localparam logic [7:0] OFS_RELAY  = 8'h10;
    localparam logic [7:0] OFS_MANUAL = 8'h14;
    localparam logic [7:0] OFS_FLAGS  = 8'h18;
    localparam int CTRL_UNLOCK_BIT = 0;
    localparam int CTRL_EXT_BIT    = 1;
    localparam int FLAG_PAUSED_BIT = 0;
    localparam int FLAG_VIEW_BIT   = 1;
    localparam int FLAG_DISP_BIT   = 2;
    localparam int FLAG_REJ_BIT    = 3;
endpackage

//--- core/pco_top.sv
// override control top: APB registers, command decode, channel array
`timescale 1ns/1ps
module pco_top import pco_pkg::*; #(
    parameter int N_CH       = NCH,
    parameter int PERIOD_CYC = BLINK_PERIOD_CYC,
    parameter int INV_CYC    = BLINK_INV_CYC,
    parameter int SEC_C      = SEC_CYC
) (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // external enable option
    input  wire logic [N_CH-1:0] ext_en_n,
    output logic [N_CH-1:0]      status_n,
    // front panel
    output logic [N_CH-1:0]      indicator,
    output logic                 disp_pressure
);
    typedef struct packed {
        logic            unlock;
        logic            ext;
        logic [N_CH-1:0] press_ok;
        logic [TO_W-1:0] to_sec;
        logic            paused;
        logic            view;
        logic            disp;
        logic            rejected;
        logic [N_CH-1:0] toggle;
        logic [N_CH-1:0] release_v;
        logic            pause_rst;
        logic            restart;
        logic [N_CH-1:0] sy1;
        logic [N_CH-1:0] sy2;
        logic [N_CH-1:0] cond;
        logic [N_CH-1:0] status_n;
        logic [N_CH-1:0] ind;
        logic [31:0]     rdata;
        logic            ready;
        logic            err;
    } pco_top_st_t;
    pco_top_st_t s, n;

    wire logic [N_CH-1:0] relay_v;
    wire logic [N_CH-1:0] manual_v;
    logic                 setup;
    logic                 access;
    logic                 wr_cmd;
    logic                 ok_cmd;
    logic [6:0]           code;
    logic [31:0]          wmask;

    pco_ctl_if #(.N(N_CH), .TW(TO_W)) bus ();

    assign setup  = psel && !penable;
    assign access = psel && penable && s.ready;
    assign wr_cmd = access && pwrite && !s.err && (paddr == OFS_CMD) && pstrb[0];
    assign ok_cmd = wr_cmd && s.unlock;
    assign code   = pwdata[6:0];
    assign wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    always_comb begin
        logic        hit;
        logic [31:0] tmp;
        hit = 1'b0;
        tmp = '0;
        n = s;
        n.toggle    = '0;
        n.release_v = '0;
        n.pause_rst = 1'b0;
        n.restart   = 1'b0;
        // first stage only feeds the second stage
        n.sy1 = ext_en_n;
        n.sy2 = s.sy1;
        n.cond = s.press_ok & (s.ext ? ~s.sy2 : {N_CH{1'b1}});
        n.status_n = ~relay_v;
        // paused channels blink as well, as do manual ones
        n.ind = relay_v ^ ((manual_v | {N_CH{s.paused}})
                & {N_CH{bus.blink_inv}});

        // apb: read data and error captured in setup, answered next cycle
        n.ready = setup;
        // error only stands with pready, so the output needs no gating
        n.err   = 1'b0;
        if (setup) begin
            n.err   = 1'b0;
            n.rdata = '0;
            unique case (paddr)
                OFS_CMD:    n.rdata = '0;
                OFS_CTRL: begin
                    n.rdata[CTRL_UNLOCK_BIT] = s.unlock;
                    n.rdata[CTRL_EXT_BIT]    = s.ext;
                end
                OFS_PRESS:  n.rdata[N_CH-1:0] = s.press_ok;
                OFS_TO:     n.rdata[TO_W-1:0] = s.to_sec;
                OFS_RELAY:  n.rdata[N_CH-1:0] = relay_v;
                OFS_MANUAL: n.rdata[N_CH-1:0] = manual_v;
                OFS_FLAGS: begin
                    n.rdata[FLAG_PAUSED_BIT] = s.paused;
                    n.rdata[FLAG_VIEW_BIT]   = s.view;
                    n.rdata[FLAG_DISP_BIT]   = s.disp;
                    n.rdata[FLAG_REJ_BIT]    = s.rejected;
                end
                default:    n.err = 1'b1;
            endcase
        end

        if (access && pwrite && !s.err) begin
            tmp = '0;
            unique case (paddr)
                OFS_CTRL: begin
                    tmp[CTRL_UNLOCK_BIT] = s.unlock;
                    tmp[CTRL_EXT_BIT]    = s.ext;
                    tmp = merge(tmp, pwdata, wmask);
                    n.unlock = tmp[CTRL_UNLOCK_BIT];
                    n.ext    = tmp[CTRL_EXT_BIT];
                end
                OFS_PRESS: begin
                    tmp[N_CH-1:0] = s.press_ok;
                    tmp = merge(tmp, pwdata, wmask);
                    n.press_ok = tmp[N_CH-1:0];
                end
                OFS_TO: begin
                    tmp[TO_W-1:0] = s.to_sec;
                    tmp = merge(tmp, pwdata, wmask);
                    n.to_sec = tmp[TO_W-1:0];
                end
                default: ;
            endcase
        end

        if (wr_cmd && !s.unlock) begin
            n.rejected = 1'b1;
        end else if (ok_cmd) begin
            n.rejected = 1'b0;
            n.disp = s.view;
            if (code == CODE_PAUSE) begin
                n.paused = 1'b1;
            end else if (code == CODE_PAUSE_RST) begin
                n.paused    = 1'b1;
                n.pause_rst = 1'b1;
            end else if (code == CODE_RESTART) begin
                n.paused  = 1'b0;
                n.restart = 1'b1;
            end else if (code == CODE_VIEW) begin
                n.view = 1'b1;
                n.disp = 1'b1;
            end else begin
                // override and return codes never touch the pause state
                for (int i = 0; i < N_CH; i++) begin
                    if (code == CODE_MAN_BASE + 7'(i)) begin
                        n.toggle[i] = 1'b1;
                        hit = 1'b1;
                    end
                    if (code == CODE_AUTO_BASE + 7'(i)) begin
                        n.release_v[i] = 1'b1;
                        hit = 1'b1;
                    end
                end
                if (!hit) begin
                    n.disp = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.to_sec <= TO_RST;
            s.sy1 <= {N_CH{1'b1}};
            s.sy2 <= {N_CH{1'b1}};
            s.status_n <= {N_CH{1'b1}};
        end else begin
            s <= n;
        end
    end

    assign bus.paused    = s.paused;
    assign bus.pause_rst = s.pause_rst;
    assign bus.restart   = s.restart;
    assign bus.toggle    = s.toggle;
    assign bus.release_v = s.release_v;
    assign bus.cond      = s.cond;
    assign bus.to_sec    = s.to_sec;

    pco_blink #(
        .PERIOD_CYC (PERIOD_CYC),
        .INV_CYC    (INV_CYC),
        .SEC_C      (SEC_C)
    ) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (bus.tmr)
    );

    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        pco_chan #(.IDX(g)) u_ch (
            .pclk    (pclk),
            .presetn (presetn),
            .c       (bus.chan),
            .relay   (relay_v[g]),
            .manual  (manual_v[g])
        );
    end

    assign prdata        = s.rdata;
    assign pready        = s.ready;
    assign pslverr       = s.err;
    assign status_n      = s.status_n;
    assign indicator     = s.ind;
    assign disp_pressure = s.disp;

    chk_tog_decode: assert property (@(posedge pclk) disable iff (!presetn)
        ok_cmd && code == CODE_MAN_BASE |=> s.toggle == N_CH'(1) && s.release_v == '0)
        else $error("first toggle code not decoded to channel one");
    chk_auto_decode: assert property (@(posedge pclk) disable iff (!presetn)
        ok_cmd && code == CODE_AUTO_BASE + 7'(N_CH - 1)
        |=> s.release_v[N_CH-1] && $onehot(s.release_v) && s.toggle == '0)
        else $error("last return code not decoded to last channel");
    chk_lock_reject: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cmd && !s.unlock |=> s.toggle == '0 && s.release_v == '0
        && s.rejected && $stable(s.paused))
        else $error("command accepted while locked");
    chk_pause_keep: assert property (@(posedge pclk) disable iff (!presetn)
        ok_cmd && (code == CODE_MAN_BASE || code == CODE_AUTO_BASE)
        |=> $stable(s.paused) && !s.pause_rst && !s.restart)
        else $error("override code altered pause state");
    chk_view_disp: assert property (@(posedge pclk) disable iff (!presetn)
        ok_cmd && s.view && code == CODE_AUTO_BASE |=> disp_pressure)
        else $error("pressure view lost on return code");
    chk_ext_gate: assert property (@(posedge pclk) disable iff (!presetn)
        s.ext |=> s.cond == ($past(s.press_ok) & ~$past(s.sy2)))
        else $error("enable not gated by external input");
    chk_status_low: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_n == ~$past(relay_v))
        else $error("status output not inverse of channel state");
    chk_steady_ind: assert property (@(posedge pclk) disable iff (!presetn)
        !manual_v[0] && !s.paused |=> indicator[0] == ~status_n[0])
        else $error("automatic channel indicator blinked");
    chk_blink_ind: assert property (@(posedge pclk) disable iff (!presetn)
        manual_v[0] && bus.blink_inv |=> indicator[0] == status_n[0])
        else $error("manual channel indicator not inverted");
endmodule

//--- test/pco_ext_model.sv
// switch, contact and linked-channel model driving the external enable inputs
`timescale 1ns/1ps
module pco_ext_model #(
    parameter int N = 12
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // contact closures and channel link from the bench
    input  wire logic [N-1:0] close,
    input  wire logic         link_en,
    // status outputs of the block
    input  wire logic [N-1:0] status_n,
    // enable inputs of the block
    output logic [N-1:0]      ext_en_n
);
    logic [N-1:0] line_nxt;

    // open contact floats high through the input pull-up
    always_comb begin
        line_nxt = ~close;
        if (link_en) begin
            line_nxt[1] = status_n[0];
        end
    end

    // lines move just after the clock edge, never mid-cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_en_n <= '1;
        end else begin
            ext_en_n <= line_nxt;
        end
    end
endmodule

//--- test/process_channel_override_ctrl_tb_top.sv
// self-checking bench for the override control top
`timescale 1ns/1ps
module process_channel_override_ctrl_tb_top import pco_pkg::*;;
    localparam int NC = 12;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic [31:0]   rq;
    logic [3:0]    pstrb;
    logic          pready;
    logic          pslverr;
    logic          er;
    logic          link_en;
    logic          disp_pressure;
    logic [NC-1:0] ext_en_n;
    logic [NC-1:0] status_n;
    logic [NC-1:0] indicator;
    logic [NC-1:0] close;
    int            mismatches;
    int            checks;

    pco_top #(.N_CH(NC), .PERIOD_CYC(40), .INV_CYC(10), .SEC_C(20)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_en_n(ext_en_n), .status_n(status_n), .indicator(indicator),
        .disp_pressure(disp_pressure));

    pco_ext_model #(.N(NC)) i_ext (
        .pclk(pclk), .presetn(presetn), .close(close), .link_en(link_en),
        .status_n(status_n), .ext_en_n(ext_en_n));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // request held until the edge that samples pready; data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rq = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rq);
    endtask

    // state settles two edges after the access edge; four are waited
    task automatic cmd(input logic [6:0] code);
        apb(1'b1, OFS_CMD, {25'h0, code});
        repeat (4) @(posedge pclk);
    endtask

    task automatic t_reset();
        chk("status_n", 32'hFFF, {20'h0, status_n});
        chk("indicator", 32'h0, {20'h0, indicator});
        rdc("ctrl", OFS_CTRL, 32'h0);
        rdc("timeout", OFS_TO, 32'h0000000A);
        rdc("manual", OFS_MANUAL, 32'h0);
        rdc("flags", OFS_FLAGS, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        $display("test reset done");
    endtask

    task automatic t_locked();
        cmd(7'h29);
        rdc("manual", OFS_MANUAL, 32'h0);
        rdc("flags", OFS_FLAGS, 32'h00000008);
        $display("test locked done");
    endtask

    task automatic t_toggle();
        int inv;
        apb(1'b1, OFS_CTRL, 32'h1);
        for (int i = 0; i < NC; i++) begin
            cmd(7'h29 + 7'(i));
            rdc("manual", OFS_MANUAL, (32'h2 << i) - 32'h1);
            rdc("relay", OFS_RELAY, 32'h0);
        end
        cmd(7'h29);
        rdc("relay", OFS_RELAY, 32'h1);
        chk("status_n", 32'hFFE, {20'h0, status_n});
        inv = 0;
        repeat (40) begin
            @(negedge pclk);
            if (indicator[0] !== 1'b1) inv++;
        end
        chk("blink cycles", 32'd10, 32'(inv));
        $display("test toggle done");
    endtask

    task automatic t_auto();
        int bad;
        for (int i = 0; i < NC; i++) begin
            cmd(7'h47 + 7'(i));
            rdc("manual", OFS_MANUAL, 32'hFFE & (32'hFFE << i));
        end
        rdc("relay", OFS_RELAY, 32'h0);
        bad = 0;
        repeat (40) begin
            @(negedge pclk);
            if (indicator !== 12'h000) bad++;
        end
        chk("steady", 32'h0, 32'(bad));
        $display("test auto done");
    endtask

    task automatic t_ext();
        apb(1'b1, OFS_CTRL, 32'h3);
        // every set point passed, so the pins alone decide
        apb(1'b1, OFS_PRESS, 32'hFFF);
        apb(1'b1, OFS_TO, 32'h2);
        repeat (10) @(posedge pclk);
        rdc("relay open", OFS_RELAY, 32'h0);
        close[2] <= 1'b1;
        repeat (8) @(posedge pclk);
        rdc("relay closed", OFS_RELAY, 32'h4);
        chk("status_n", 32'hFFB, {20'h0, status_n});
        repeat (60) @(posedge pclk);
        rdc("relay expired", OFS_RELAY, 32'h0);
        apb(1'b1, OFS_TO, 32'h0);
        close[2] <= 1'b0;
        close[0] <= 1'b1;
        link_en  <= 1'b1;
        repeat (16) @(posedge pclk);
        rdc("relay linked", OFS_RELAY, 32'h3);
        $display("test ext done");
    endtask

    task automatic t_release();
        close[3] <= 1'b1;
        repeat (10) @(posedge pclk);
        rdc("relay", OFS_RELAY, 32'hB);
        cmd(7'h2C);
        rdc("relay", OFS_RELAY, 32'hB);
        rdc("manual", OFS_MANUAL, 32'h8);
        cmd(7'h2C);
        rdc("relay", OFS_RELAY, 32'h3);
        cmd(7'h4A);
        rdc("relay", OFS_RELAY, 32'hB);
        rdc("manual", OFS_MANUAL, 32'h0);
        $display("test release done");
    endtask

    task automatic t_pause();
        cmd(7'h2E);
        cmd(7'h20);
        rdc("flags", OFS_FLAGS, 32'h1);
        cmd(7'h2E);
        rdc("relay", OFS_RELAY, 32'h2B);
        rdc("flags", OFS_FLAGS, 32'h1);
        cmd(7'h4C);
        rdc("manual", OFS_MANUAL, 32'h20);
        cmd(7'h22);
        rdc("manual", OFS_MANUAL, 32'h0);
        rdc("flags", OFS_FLAGS, 32'h0);
        rdc("relay", OFS_RELAY, 32'hB);
        cmd(7'h21);
        rdc("relay", OFS_RELAY, 32'h0);
        cmd(7'h22);
        repeat (16) @(posedge pclk);
        rdc("relay", OFS_RELAY, 32'hB);
        $display("test pause done");
    endtask

    task automatic t_view();
        cmd(7'h23);
        chk("disp", 32'h1, {31'h0, disp_pressure});
        cmd(7'h29);
        chk("disp", 32'h1, {31'h0, disp_pressure});
        cmd(7'h47);
        chk("disp", 32'h1, {31'h0, disp_pressure});
        cmd(7'h01);
        chk("disp", 32'h0, {31'h0, disp_pressure});
        cmd(7'h29);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc("manual", OFS_MANUAL, 32'h0);
        chk("disp", 32'h0, {31'h0, disp_pressure});
        $display("test view done");
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        pstrb   = 4'hF;
        close   = '0;
        link_en = 1'b0;
        mismatches = 0;
        checks  = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_locked();
        t_toggle();
        t_auto();
        t_ext();
        t_release();
        t_pause();
        t_view();
        tally_and_finish();
    end
endmodule
